// File: common/ifb_pkg.sv
// Purpose: shared constants and types for the interrupt flag/enable bank
// Assumes: 16-bit registers at half-word byte offsets on a plain port
// Notes:   masks are built from the implemented bit positions below
package ifb_pkg;

    // register geometry and bus widths
    localparam int unsigned REG_W  = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned NUM_FLAG_REGS = 4;

    // byte offsets of the five registers
    localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_TWO     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_THREE   = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_FOUR    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_FIVE    = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_ENABLE_CONTROL_ZERO = 8'h08;

    // value of every implemented bit at reset
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

    // flag status two field positions
    localparam int unsigned PARALLEL_PORT_FLAG = 13, COMPARE8_FLAG = 12, COMPARE7_FLAG = 11,
        COMPARE6_FLAG = 10, COMPARE5_FLAG = 9, CAPTURE6_FLAG = 8, CAPTURE5_FLAG = 7,
        CAPTURE4_FLAG = 6, CAPTURE3_FLAG = 5, SERIAL_PERIPH2_EVENT_FLAG = 1,
        SERIAL_PERIPH2_FAULT_FLAG = 0;
    // flag status three field positions
    localparam int unsigned CALENDAR_FLAG = 14, EXT_IRQ4_FLAG = 6, EXT_IRQ3_FLAG = 5,
        TWO_WIRE2_MASTER_FLAG = 2, TWO_WIRE2_SLAVE_FLAG = 1;
    // flag status four field positions
    localparam int unsigned CAP_TIMING_FLAG = 13, LOW_VOLTAGE_FLAG = 8,
        CHECKSUM_GEN_FLAG = 3, SERIAL2_ERROR_FLAG = 2, SERIAL1_ERROR_FLAG = 1;
    // flag status five field positions
    localparam int unsigned CAPTURE9_FLAG = 13, COMPARE9_FLAG = 12,
        SERIAL_PERIPH3_EVENT_FLAG = 11, SERIAL_PERIPH3_FAULT_FLAG = 10,
        SERIAL4_TX_FLAG = 9, SERIAL4_RX_FLAG = 8, SERIAL4_ERROR_FLAG = 7,
        TWO_WIRE3_MASTER_FLAG = 5, TWO_WIRE3_SLAVE_FLAG = 4, SERIAL3_TX_FLAG = 3,
        SERIAL3_RX_FLAG = 2, SERIAL3_ERROR_FLAG = 1;
    // enable control zero field positions
    localparam int unsigned ADC_DONE_ENABLE = 13, SERIAL1_TX_ENABLE = 12,
        SERIAL1_RX_ENABLE = 11, SERIAL_PERIPH1_DONE_ENABLE = 10,
        SERIAL_PERIPH1_FAULT_ENABLE = 9, TIMER_THREE_ENABLE = 8, TIMER_TWO_ENABLE = 7,
        COMPARE2_ENABLE = 6, CAPTURE2_ENABLE = 5, TIMER_ONE_ENABLE = 3,
        COMPARE1_ENABLE = 2, CAPTURE1_ENABLE = 1, EXT_IRQ0_ENABLE = 0;

    // implemented-bit masks; every other position reads zero
    localparam logic [REG_W-1:0] MASK_FLAG_TWO = 16'(
        (1 << PARALLEL_PORT_FLAG) | (1 << COMPARE8_FLAG) | (1 << COMPARE7_FLAG) |
        (1 << COMPARE6_FLAG) | (1 << COMPARE5_FLAG) | (1 << CAPTURE6_FLAG) |
        (1 << CAPTURE5_FLAG) | (1 << CAPTURE4_FLAG) | (1 << CAPTURE3_FLAG) |
        (1 << SERIAL_PERIPH2_EVENT_FLAG) | (1 << SERIAL_PERIPH2_FAULT_FLAG));
    localparam logic [REG_W-1:0] MASK_FLAG_THREE = 16'(
        (1 << CALENDAR_FLAG) | (1 << EXT_IRQ4_FLAG) | (1 << EXT_IRQ3_FLAG) |
        (1 << TWO_WIRE2_MASTER_FLAG) | (1 << TWO_WIRE2_SLAVE_FLAG));
    localparam logic [REG_W-1:0] MASK_FLAG_FOUR = 16'(
        (1 << CAP_TIMING_FLAG) | (1 << LOW_VOLTAGE_FLAG) | (1 << CHECKSUM_GEN_FLAG) |
        (1 << SERIAL2_ERROR_FLAG) | (1 << SERIAL1_ERROR_FLAG));
    localparam logic [REG_W-1:0] MASK_FLAG_FIVE = 16'(
        (1 << CAPTURE9_FLAG) | (1 << COMPARE9_FLAG) | (1 << SERIAL_PERIPH3_EVENT_FLAG) |
        (1 << SERIAL_PERIPH3_FAULT_FLAG) | (1 << SERIAL4_TX_FLAG) | (1 << SERIAL4_RX_FLAG) |
        (1 << SERIAL4_ERROR_FLAG) | (1 << TWO_WIRE3_MASTER_FLAG) |
        (1 << TWO_WIRE3_SLAVE_FLAG) | (1 << SERIAL3_TX_FLAG) | (1 << SERIAL3_RX_FLAG) |
        (1 << SERIAL3_ERROR_FLAG));
    localparam logic [REG_W-1:0] MASK_ENABLE_ZERO = 16'(
        (1 << ADC_DONE_ENABLE) | (1 << SERIAL1_TX_ENABLE) | (1 << SERIAL1_RX_ENABLE) |
        (1 << SERIAL_PERIPH1_DONE_ENABLE) | (1 << SERIAL_PERIPH1_FAULT_ENABLE) |
        (1 << TIMER_THREE_ENABLE) | (1 << TIMER_TWO_ENABLE) | (1 << COMPARE2_ENABLE) |
        (1 << CAPTURE2_ENABLE) | (1 << TIMER_ONE_ENABLE) | (1 << COMPARE1_ENABLE) |
        (1 << CAPTURE1_ENABLE) | (1 << EXT_IRQ0_ENABLE));

    // flag registers indexed 0..3 for flag status two..five
    localparam logic [NUM_FLAG_REGS-1:0][REG_W-1:0] FLAG_MASKS =
        {MASK_FLAG_FIVE, MASK_FLAG_FOUR, MASK_FLAG_THREE, MASK_FLAG_TWO};
    localparam logic [NUM_FLAG_REGS-1:0][ADDR_W-1:0] FLAG_OFFS =
        {OFF_FLAG_STATUS_FIVE, OFF_FLAG_STATUS_FOUR, OFF_FLAG_STATUS_THREE,
         OFF_FLAG_STATUS_TWO};

    // one register-port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // byte offset
        logic [REG_W-1:0]  wdata;  // write data
        logic              wr;     // write strobe
        logic              rd;     // read strobe
    } ifb_bus_t;

    // per-register bit vectors for the four flag registers
    typedef logic [NUM_FLAG_REGS-1:0][REG_W-1:0] ifb_flag_vec_t;

endpackage : ifb_pkg

// File: logic/ifb_bank.sv
// Purpose: flag status two..five and enable control zero, with register port
// Assumes: one clock; strobes single-cycle and never both at once
// Notes:   read data stand only in the cycle after the read strobe
//
// How it works
// - flag reads one after its source requests
// - enable one passes request, zero blocks
// - unimplemented bits read zero, ignore writes
// - every flag and enable resets to zero
// - software reads and writes all implemented bits
// - flag two holds port, compare, capture, serial
// - flag three holds calendar, external, two-wire
// - flag four holds timing, voltage, checksum, errors
// - flag five holds capture9, compare9, serial groups
// - enable zero holds adc, serial, timer, compare
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module ifb_bank
    import ifb_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                reset_n_in,
    input  wire ifb_bus_t            bus_in,          // register port request
    output logic      [REG_W-1:0]    rd_data_out,     // read answer, one cycle later
    input  wire ifb_flag_vec_t       flag_set_in,     // peripheral set pulses
    input  wire ifb_flag_vec_t       ext_enable_in,   // enables held elsewhere
    input  wire logic [REG_W-1:0]    ext_flag_zero_in,// flags gated by enable zero
    output ifb_flag_vec_t            flag_req_out,    // gated flag requests
    output logic      [REG_W-1:0]    zero_req_out,    // gated enable-zero requests
    output logic                     core_req_out     // any request to the core
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [NUM_FLAG_REGS-1:0] flag_hit;    // address matches a flag register
    logic                     enable_hit;  // address matches enable zero
    logic                     any_hit;     // address is mapped

    // one comparator per flag register
    for (genvar r = 0; r < NUM_FLAG_REGS; r++) begin : g_dec
        assign flag_hit[r] = (bus_in.addr == FLAG_OFFS[r]);
    end
    assign enable_hit = (bus_in.addr == OFF_ENABLE_CONTROL_ZERO);
    assign any_hit    = (|flag_hit) | enable_hit;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    ifb_flag_vec_t    flag_val;    // current flag registers
    ifb_flag_vec_t    set_masked;  // set pulses on implemented bits only
    logic [REG_W-1:0] enable_val;  // current enable zero

    // flag status two..five share one module, differing only in mask
    for (genvar r = 0; r < NUM_FLAG_REGS; r++) begin : g_flag
        ifb_flag_reg #(
            .MASK (FLAG_MASKS[r])
        ) u_flag (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .wr_en_in   (bus_in.wr & flag_hit[r]),
            .wr_data_in (bus_in.wdata),
            .set_in     (flag_set_in[r]),
            .value_out  (flag_val[r])
        );
        assign set_masked[r] = flag_set_in[r] & FLAG_MASKS[r];
        // a source requests only while its flag and enable are both set
        assign flag_req_out[r] = flag_val[r] & ext_enable_in[r];
    end

    // enable control zero gates the flags kept outside this bank
    ifb_enable_reg #(
        .MASK (MASK_ENABLE_ZERO)
    ) u_enable (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .wr_en_in   (bus_in.wr & enable_hit),
        .wr_data_in (bus_in.wdata),
        .flags_in   (ext_flag_zero_in),
        .value_out  (enable_val),
        .req_out    (zero_req_out)
    );

    // single request line toward the core
    assign core_req_out = (|flag_req_out) | (|zero_req_out);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [REG_W-1:0] rd_data_d;  // selected register value
    logic [REG_W-1:0] rd_data_q;  // registered answer

    // select the addressed register; unmapped reads answer zero
    always_comb begin
        rd_data_d = '0;
        if (bus_in.rd) begin
            for (int r = 0; r < NUM_FLAG_REGS; r++) begin
                if (flag_hit[r]) begin
                    rd_data_d = flag_val[r];
                end
            end
            if (enable_hit) begin
                rd_data_d = enable_val;
            end
        end
    end

    // answer stands for exactly one cycle, zero otherwise
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end
    assign rd_data_out = rd_data_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    ifb_flag_vec_t    wr_masked;   // write data per flag register, masked
    logic [REG_W-1:0] wr_en_mask;  // write data masked for enable zero
    ifb_flag_vec_t    flag_hit_wr; // write strobe spread over flag registers

    // helper values for the assertions below
    for (genvar r = 0; r < NUM_FLAG_REGS; r++) begin : g_chk
        assign wr_masked[r]   = bus_in.wdata & FLAG_MASKS[r];
        assign flag_hit_wr[r] = {REG_W{bus_in.wr & flag_hit[r]}};
    end
    assign wr_en_mask = bus_in.wdata & MASK_ENABLE_ZERO;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // every set pulse on an implemented bit is visible next cycle
    chk_flag_set_seen: assert property (
        (|set_masked) |=> ((flag_val & $past(set_masked)) == $past(set_masked)))
        else $error("flag set pulse not captured");

    // flags hold when neither software nor a peripheral touches them
    chk_flag_sticky: assert property (
        (!bus_in.wr && set_masked == '0) |=> $stable(flag_val))
        else $error("flag changed without cause");

    // a write to flag status two with no set lands exactly the masked data, clears included
    chk_flag_write: assert property (
        (bus_in.wr && flag_hit[0] && set_masked[0] == '0)
            |=> (flag_val[0] == $past(wr_masked[0])))
        else $error("flag status two write not stored");

    // a set in the cycle of a clearing write still wins
    chk_set_beats_clear: assert property (
        (bus_in.wr && (set_masked != '0))
            |=> ((flag_val & $past(set_masked)) == $past(set_masked)))
        else $error("set lost against write");

    // enable zero takes written data on implemented bits only
    chk_enable_write: assert property (
        (bus_in.wr && enable_hit) |=> (enable_val == $past(wr_en_mask)))
        else $error("enable zero write not stored");

    // no enable-zero request passes a cleared enable
    chk_enable_gate: assert property (
        ((zero_req_out & ~enable_val) == '0)
            && (zero_req_out == (ext_flag_zero_in & enable_val)))
        else $error("enable gating wrong");

    // unimplemented positions never read one
    chk_unimpl_zero: assert property (
        ((flag_val & ~FLAG_MASKS) == '0) && ((enable_val & ~MASK_ENABLE_ZERO) == '0))
        else $error("unimplemented bit set");

    // read of flag status four returns its value of the read cycle
    chk_read_flag: assert property (
        (bus_in.rd && flag_hit[2]) |=> (rd_data_out == $past(flag_val[2])))
        else $error("flag status four read wrong");

    // unmapped reads and idle cycles answer zero
    chk_read_idle: assert property (
        (!bus_in.rd || !any_hit) |=> (rd_data_out == '0))
        else $error("read data outside its cycle");

    // core request follows the gated flags and enables
    chk_core_request: assert property (
        core_req_out == ((|(flag_val & ext_enable_in)) | (|zero_req_out)))
        else $error("core request mismatch");

    // a set flag in flag status three with its enable produces a request in the next cycle
    chk_request_follows: assert property (
        ((set_masked[1] & ext_enable_in[1]) != '0) ##1 $stable(ext_enable_in)
            |-> core_req_out)
        else $error("request missing after set");

    // first cycle after release: nothing pending, nothing enabled
    chk_reset_clear: assert property (
        !$past(reset_n_in) |-> (flag_val == '0 && enable_val == '0 && !core_req_out))
        else $error("state not cleared by reset");

    // first cycle after release: no stale read answer
    chk_reset_read: assert property (
        !$past(reset_n_in) |-> (rd_data_out == '0))
        else $error("read data not cleared by reset");

    // per flag register: masked write lands, read returns the read-cycle value
    for (genvar r = 0; r < NUM_FLAG_REGS; r++) begin : g_reg_chk
        // a write with no peripheral set lands exactly as masked
        chk_write_each: assert property (
            (bus_in.wr && flag_hit[r] && set_masked[r] == '0)
                |=> (flag_val[r] == $past(wr_masked[r])))
            else $error("flag register write not stored");

        // the answer is the register as it stood in the read cycle
        chk_read_each: assert property (
            (bus_in.rd && flag_hit[r]) |=> (rd_data_out == $past(flag_val[r])))
            else $error("flag register read wrong");
    end

    // reading enable zero returns its value of the read cycle
    chk_read_enable: assert property (
        (bus_in.rd && enable_hit) |=> (rd_data_out == $past(enable_val)))
        else $error("enable zero read wrong");

    // a nonzero answer only ever follows a read strobe
    chk_read_gap: assert property (
        (rd_data_out != '0) |-> $past(bus_in.rd))
        else $error("read data without a read");

    // a write to one register leaves the other flag registers alone
    chk_write_isolated: assert property (
        (set_masked == '0)
            |=> (((flag_val ^ $past(flag_val)) & ~$past(flag_hit_wr)) == '0))
        else $error("flag changed by a write elsewhere");

    // enable zero changes only through its own write
    chk_enable_hold: assert property (
        !(bus_in.wr && enable_hit) |=> $stable(enable_val))
        else $error("enable zero changed without a write");

    // writes to unmapped offsets touch nothing
    chk_unmapped_write: assert property (
        (bus_in.wr && !any_hit && set_masked == '0)
            |=> ($stable(flag_val) && $stable(enable_val)))
        else $error("unmapped write changed a register");

    // a request needs both its flag and its enable
    chk_request_needs_both: assert property (
        ((flag_req_out & ~flag_val) == '0) && ((flag_req_out & ~ext_enable_in) == '0))
        else $error("request without flag and enable");

    // unimplemented positions never request
    chk_request_unimpl: assert property (
        ((flag_req_out & ~FLAG_MASKS) == '0) && ((zero_req_out & ~MASK_ENABLE_ZERO) == '0))
        else $error("request from an unimplemented bit");

    // with every request low the core sees nothing
    chk_core_idle: assert property (
        (flag_req_out == '0 && zero_req_out == '0) |-> !core_req_out)
        else $error("core request with nothing pending");

endmodule : ifb_bank

// File: logic/ifb_enable_reg.sv
// Purpose: 16-bit interrupt enable register with request gating
// Assumes: the flags it gates live outside this bank
// Notes:   unimplemented positions are constant zero
`timescale 1ns/100ps
module ifb_enable_reg
    import ifb_pkg::*;
#(
    parameter logic [REG_W-1:0] MASK = 16'h0000
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             wr_en_in,     // software write this cycle
    input  wire logic [REG_W-1:0] wr_data_in,   // software write value
    input  wire logic [REG_W-1:0] flags_in,     // matching flag bits
    output logic      [REG_W-1:0] value_out,    // current enables
    output logic      [REG_W-1:0] req_out       // flag and enable both set
);

    for (genvar b = 0; b < REG_W; b++) begin : g_bit
        if (MASK[b]) begin : g_impl
            logic en_q;  // enable bit
            // plain read/write storage
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    en_q <= REG_RESET[b];
                end else if (wr_en_in) begin
                    en_q <= wr_data_in[b];
                end
            end
            assign value_out[b] = en_q;
            assign req_out[b]   = flags_in[b] & en_q;
        end else begin : g_none
            assign value_out[b] = 1'b0;
            assign req_out[b]   = 1'b0;
        end
    end

endmodule : ifb_enable_reg

// File: logic/ifb_flag_reg.sv
// Purpose: one 16-bit sticky interrupt flag register
// Assumes: set pulses come from peripherals in the clk_in domain
// Notes:   unimplemented positions are constant zero
`timescale 1ns/100ps
module ifb_flag_reg
    import ifb_pkg::*;
#(
    parameter logic [REG_W-1:0] MASK = 16'h0000
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             wr_en_in,     // software write this cycle
    input  wire logic [REG_W-1:0] wr_data_in,   // software write value
    input  wire logic [REG_W-1:0] set_in,       // peripheral request pulses
    output logic      [REG_W-1:0] value_out     // current flags
);

    // one flop per implemented bit, none for the rest
    for (genvar b = 0; b < REG_W; b++) begin : g_bit
        if (MASK[b]) begin : g_impl
            logic flag_q;  // sticky flag
            // peripheral set checked before the software write, so a set wins
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    flag_q <= REG_RESET[b];
                end else if (set_in[b]) begin
                    flag_q <= 1'b1;
                end else if (wr_en_in) begin
                    flag_q <= wr_data_in[b];
                end
            end
            assign value_out[b] = flag_q;
        end else begin : g_none
            assign value_out[b] = 1'b0;
        end
    end

endmodule : ifb_flag_reg

// File: verif/ifb_bank_bench.sv
// Purpose: self-checking bench for the flag/enable bank
// Assumes: register port with single-cycle strobes, read data one cycle later
// Notes:   expected masks are written out from the bit maps, not the package
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module ifb_bank_bench;
    import ifb_pkg::*;

    // one register access row: address, write value, value read back
    typedef struct {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } ifb_row_t;

    logic                clk_in;           // system clock
    logic                reset_n_in;       // async reset, active low
    ifb_bus_t            bus_in;           // register port request
    logic [REG_W-1:0]    rd_data_out;      // read answer
    ifb_flag_vec_t       flag_set_in;      // set pulses from the model
    ifb_flag_vec_t       ext_enable_in;    // enables held outside
    logic [REG_W-1:0]    ext_flag_zero_in; // flags held outside
    ifb_flag_vec_t       flag_req_out;     // gated flag requests
    logic [REG_W-1:0]    zero_req_out;     // gated enable-zero requests
    logic                core_req_out;     // request to the core
    int                  mismatches;       // failed compares
    int                  tests_run;        // compares made
    int                  cycles;           // timeout count
    logic [15:0]         fl_mask [4];      // implemented flag bits per register
    ifb_row_t            rows [17];        // ordinary register accesses

    ifb_bank u_ifb_bank (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus_in),
        .rd_data_out(rd_data_out), .flag_set_in(flag_set_in),
        .ext_enable_in(ext_enable_in), .ext_flag_zero_in(ext_flag_zero_in),
        .flag_req_out(flag_req_out), .zero_req_out(zero_req_out),
        .core_req_out(core_req_out));
    ifb_periph_model u_ifb_periph_model (.clk_in(clk_in), .set_out(flag_set_in));

    // free-running 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // cut a hang short
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end

    // print counts and the verdict, then stop
    task automatic results();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // one write cycle; the update lands at the strobe edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_in.addr  <= a;
        bus_in.wdata <= d;
        bus_in.wr    <= 1'b1;
        @(posedge clk_in);
        bus_in.wr    <= 1'b0;
        #1;
    endtask : wr

    // one read cycle; data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        bus_in.addr <= a;
        bus_in.rd   <= 1'b1;
        @(posedge clk_in);
        bus_in.rd   <= 1'b0;
        #1;
        `CHK(rd_data_out, exp)
        @(posedge clk_in);
        #1;
        `CHK(rd_data_out, 16'h0000)
    endtask : rd

    initial begin
        bus_in           = '0;
        ext_enable_in    = '0;
        ext_flag_zero_in = '0;
        reset_n_in       = 1'b0;
        mismatches       = 0;
        tests_run        = 0;
        cycles           = 0;
        fl_mask = '{16'h3fe3, 16'h4066, 16'h210e, 16'h3fbe};
        // per register: all ones, a pattern, all zeros; then unmapped places
        rows = '{'{8'h00, 16'hffff, 16'h3fe3}, '{8'h00, 16'ha5a5, 16'h25a1},
            '{8'h00, 16'h0000, 16'h0000}, '{8'h02, 16'hffff, 16'h4066},
            '{8'h02, 16'ha5a5, 16'h0024}, '{8'h02, 16'h0000, 16'h0000},
            '{8'h04, 16'hffff, 16'h210e}, '{8'h04, 16'ha5a5, 16'h2104},
            '{8'h04, 16'h0000, 16'h0000}, '{8'h06, 16'hffff, 16'h3fbe},
            '{8'h06, 16'ha5a5, 16'h25a4}, '{8'h06, 16'h0000, 16'h0000},
            '{8'h08, 16'hffff, 16'h3fef}, '{8'h08, 16'ha5a5, 16'h25a5},
            '{8'h08, 16'h0000, 16'h0000}, '{8'h0a, 16'hffff, 16'h0000},
            '{8'h01, 16'hffff, 16'h0000}};
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // everything clear after power-on
        for (int i = 0; i < 5; i++) rd(8'(2 * i), 16'h0000);
        `CHK(core_req_out, 1'b0)
        // table of ordinary accesses
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].exp);
        end
        // every source of each flag register, then gating and clearing
        for (int r = 0; r < 4; r++) begin
            u_ifb_periph_model.raise(r, 16'hffff);
            rd(8'(2 * r), fl_mask[r]);
            `CHK(core_req_out, 1'b0)
            @(posedge clk_in);
            ext_enable_in[r] <= 16'hffff;
            #1;
            `CHK(flag_req_out[r], fl_mask[r])
            `CHK(core_req_out, 1'b1)
            wr(8'(2 * r), 16'h0000);
            `CHK(flag_req_out[r], 16'h0000)
            rd(8'(2 * r), 16'h0000);
            @(posedge clk_in);
            ext_enable_in[r] <= 16'h0000;
        end
        // enable zero gating of the outside flags
        @(posedge clk_in);
        ext_flag_zero_in <= 16'hffff;
        #1;
        `CHK(zero_req_out, 16'h0000)
        wr(8'h08, 16'h2401);
        `CHK(zero_req_out, 16'h2401)
        `CHK(core_req_out, 1'b1)
        wr(8'h08, 16'hffff);
        `CHK(zero_req_out, 16'h3fef)
        wr(8'h08, 16'h0000);
        `CHK(zero_req_out, 16'h0000)
        `CHK(core_req_out, 1'b0)
        // a set in the same cycle as a clearing write keeps the flag
        fork
            u_ifb_periph_model.raise(0, 16'h0001);
            wr(8'h00, 16'h0000);
        join
        rd(8'h00, 16'h0001);
        // an enabled source requests once its flag sets, until software clears it
        @(posedge clk_in);
        ext_enable_in[1] <= 16'h4000;
        u_ifb_periph_model.raise(1, 16'h4000);
        #1;
        `CHK(flag_req_out[1], 16'h4000)
        repeat (3) @(posedge clk_in);
        #1;
        `CHK(core_req_out, 1'b1)
        wr(8'h02, 16'h0000);
        `CHK(core_req_out, 1'b0)
        @(posedge clk_in);
        ext_enable_in[1] <= 16'h0000;
        // reset in mid-run clears flags and enables
        wr(8'h08, 16'hffff);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        #1;
        `CHK(zero_req_out, 16'h0000)
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(8'h00, 16'h0000);
        rd(8'h08, 16'h0000);
        results();
    end
endmodule : ifb_bank_bench

// File: verif/ifb_periph_model.sv
// Purpose: peripheral side that raises flag set pulses into the bank
// Assumes: one clock shared with the bank
// Notes:   each raise is one cycle long, launched just after a rising edge
`timescale 1ns/100ps
module ifb_periph_model
    import ifb_pkg::*;
(
    input  wire logic    clk_in,     // system clock
    output ifb_flag_vec_t set_out    // set pulses toward the flag registers
);
    // idle: no source is requesting
    initial begin
        set_out = '0;
    end

    // pulse the given bits of one flag register for exactly one cycle
    task automatic raise(input int unsigned idx, input logic [REG_W-1:0] bits);
        @(posedge clk_in);
        set_out[idx] <= bits;
        @(posedge clk_in);
        set_out      <= '0;      // released, so only a sticky flag can remain
    endtask : raise
endmodule : ifb_periph_model
